/* sim/dac_test_and_delay_config_regs_tb.sv */
`timescale 1ns/1ps
// ==========================================
// Register slice testbench
// ==========================================
module dac_test_and_delay_config_regs_tb;
    logic        clock, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, wb_err_o, e;
    logic        sync_strobe_in, divider_clk_src, divider_strobe;
    logic        transmit_gate_pin, transmit_gate_bit, conv_tx_enable;
    logic [7:0]  wb_adr_i, delay_trim_chan_a, delay_trim_chan_b;
    logic [7:0]  delay_trim_chan_c, delay_trim_chan_d;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o, r;
    logic [15:0] fifo_data_in, ramp_value, proc_data, const_word;
    logic [15:0] fifo_data_out, conv_data, check_word_one;
    logic [15:0] check_word_two, check_word_three, check_word_four;
    logic [15:0] check_word_five, check_word_six, check_word_seven;
    integer      n_errors, n_compared, i;
    logic [15:0] rst_val [0:9] = '{16'hB6B6, 16'hEAEA, 16'h4545, 16'h1A1A, 16'h1616,
                                   16'hAAAA, 16'hC6C6, 16'h0004, 16'h0000, 16'h0000};

    // Free-running 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    dtr_regs #(.WIDTH(16)) DUT (
        .clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
        .sync_strobe_in(sync_strobe_in), .transmit_gate_pin(transmit_gate_pin),
        .transmit_gate_bit(transmit_gate_bit), .fifo_data_in(fifo_data_in),
        .ramp_value(ramp_value), .proc_data(proc_data), .const_word(const_word),
        .divider_clk_src(divider_clk_src), .divider_strobe(divider_strobe),
        .fifo_data_out(fifo_data_out), .conv_data(conv_data), .conv_tx_enable(conv_tx_enable),
        .check_word_one(check_word_one), .check_word_two(check_word_two),
        .check_word_three(check_word_three), .check_word_four(check_word_four),
        .check_word_five(check_word_five), .check_word_six(check_word_six),
        .check_word_seven(check_word_seven),
        .delay_trim_chan_a(delay_trim_chan_a), .delay_trim_chan_b(delay_trim_chan_b),
        .delay_trim_chan_c(delay_trim_chan_c), .delay_trim_chan_d(delay_trim_chan_d)
    );

    // Distinct data pattern per register slot
    function automatic [15:0] pat(input integer k);
        pat = 16'hA5C3 ^ {4{k[3:0]}};
    endfunction

    // Compare and count
    task chk(input [31:0] got, input [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            n_errors = n_errors + 1;
            $display("mismatch at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One classic cycle, entered just after a rising edge
    task bus(input [5:0] x, input w, input [15:0] d, input [1:0] s, output [31:0] q, output f);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= {x, 2'h0};
        wb_sel_i <= {2'h0, s};
        wb_dat_i <= {16'h0, d};
        @(posedge clock);
        // Wait for the answer; only the hang guard ends a lost cycle
        while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1) begin
            @(posedge clock);
        end
        q = wb_dat_o;
        f = wb_err_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clock);
    endtask

    // Datapath outputs in one go
    task outs(input s, input [15:0] fo, input [15:0] cd, input t);
        chk({31'h0, divider_strobe}, {31'h0, s});
        chk({16'h0, fifo_data_out}, {16'h0, fo});
        chk({16'h0, conv_data}, {16'h0, cd});
        chk({31'h0, conv_tx_enable}, {31'h0, t});
    endtask

    task tally_and_finish;
        $display("compared %0d mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Hang guard
    initial begin
        repeat (2000) @(posedge clock);
        n_errors = n_errors + 1;
        tally_and_finish;
    end

    // Main sequence
    initial begin
        n_errors = 0;
        n_compared = 0;
        reset = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
        {sync_strobe_in, divider_clk_src, transmit_gate_pin, transmit_gate_bit} = 4'h8;
        {fifo_data_in, ramp_value, proc_data, const_word} = 64'hFFFF_1234_0F0F_BEEF;
        repeat (16) @(posedge clock);
        reset <= 1'b0;
        for (i = 0; i < 10; i = i + 1) begin
            bus(6'h26 + i[5:0], 1'b0, 16'h0, 2'h3, r, e);
            chk(r, {16'h0, rst_val[i]});
        end
        $display("test reset values done");
        for (i = 0; i < 10; i = i + 1) begin
            bus(6'h26 + i[5:0], 1'b1, (i == 7) ? 16'hFFFF : pat(i), 2'h3, r, e);
        end
        for (i = 0; i < 10; i = i + 1) begin
            bus(6'h26 + i[5:0], 1'b0, 16'h0, 2'h3, r, e);
            chk(r, {16'h0, (i == 7) ? 16'h6005 : pat(i)});
        end
        chk({16'h0, check_word_one}, {16'h0, pat(0)});
        chk({check_word_two, check_word_three}, {pat(1), pat(2)});
        chk({check_word_four, check_word_five}, {pat(3), pat(4)});
        chk({check_word_six, check_word_seven}, {pat(5), pat(6)});
        chk({16'h0, delay_trim_chan_a, delay_trim_chan_b}, {16'h0, pat(8)});
        chk({16'h0, delay_trim_chan_c, delay_trim_chan_d}, {16'h0, pat(9)});
        bus(6'h26, 1'b1, 16'h0, 2'h1, r, e);
        bus(6'h26, 1'b0, 16'h0, 2'h3, r, e);
        chk(r, 32'h0000A500);
        $display("test write readback done");
        outs(1'b1, 16'h1234, 16'hBEEF, 1'b1);
        bus(6'h2D, 1'b1, 16'h0, 2'h3, r, e);
        bus(6'h2D, 1'b0, 16'h0, 2'h3, r, e);
        chk(r, 32'h4);
        outs(1'b0, 16'hFFFF, 16'h0F0F, 1'b0);
        {transmit_gate_pin, transmit_gate_bit} <= 2'h3;
        repeat (2) @(posedge clock);
        outs(1'b0, 16'hFFFF, 16'h0F0F, 1'b1);
        // One mode bit at a time, so swapped bits show up
        bus(6'h2D, 1'b1, 16'h2000, 2'h3, r, e);
        outs(1'b0, 16'h1234, 16'h0F0F, 1'b1);
        bus(6'h2D, 1'b1, 16'h4000, 2'h3, r, e);
        outs(1'b1, 16'hFFFF, 16'h0F0F, 1'b1);
        bus(6'h2D, 1'b1, 16'h0001, 2'h3, r, e);
        outs(1'b0, 16'hFFFF, 16'hBEEF, 1'b1);
        $display("test modes done");
        bus(6'h30, 1'b1, 16'hFFFF, 2'h3, r, e);
        chk({31'h0, e}, 32'h1);
        // Word zero lives outside this slice; its source alignment is the far side's
        bus(6'h25, 1'b0, 16'h0, 2'h3, r, e);
        chk(r, 32'h0);
        $display("test unmapped done");
        // Reset in mid-run must restore changed words and control
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        bus(6'h26, 1'b0, 16'h0, 2'h3, r, e);
        chk(r, 32'h0000B6B6);
        bus(6'h2D, 1'b0, 16'h0, 2'h3, r, e);
        chk(r, 32'h4);
        outs(1'b0, 16'hFFFF, 16'h0F0F, 1'b1);
        $display("test mid-run reset done");
        tally_and_finish;
    end
endmodule

// Checker bound into every instance of the register slice
bind dtr_regs dtr_regs_monitor #(.WIDTH(WIDTH)) u_mon (.clock(clock), .reset(reset),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .sync_strobe_in(sync_strobe_in), .divider_clk_src(divider_clk_src),
    .divider_strobe(divider_strobe), .transmit_gate_pin(transmit_gate_pin),
    .transmit_gate_bit(transmit_gate_bit), .proc_data(proc_data), .const_word(const_word),
    .conv_data(conv_data), .conv_tx_enable(conv_tx_enable), .check_word_one(check_word_one),
    .delay_trim_chan_a(delay_trim_chan_a), .delay_trim_chan_b(delay_trim_chan_b),
    .delay_trim_chan_c(delay_trim_chan_c), .delay_trim_chan_d(delay_trim_chan_d));

/* sim/dtr_regs_monitor.sv */
`timescale 1ns/1ps
// ==========================================
// Bus answer and mode mux checker
// ==========================================
module dtr_regs_monitor #(
    parameter WIDTH = 16
) (
    input wire             clock,
    input wire             reset,
    input wire             wb_cyc_i,
    input wire             wb_stb_i,
    input wire             wb_we_i,
    input wire [7:0]       wb_adr_i,
    input wire [3:0]       wb_sel_i,
    input wire [31:0]      wb_dat_i,
    input wire [31:0]      wb_dat_o,
    input wire             wb_ack_o,
    input wire             wb_err_o,
    input wire             sync_strobe_in,
    input wire             divider_clk_src,
    input wire             divider_strobe,
    input wire             transmit_gate_pin,
    input wire             transmit_gate_bit,
    input wire [WIDTH-1:0] proc_data,
    input wire [WIDTH-1:0] const_word,
    input wire [WIDTH-1:0] conv_data,
    input wire             conv_tx_enable,
    input wire [WIDTH-1:0] check_word_one,
    input wire [7:0]       delay_trim_chan_a,
    input wire [7:0]       delay_trim_chan_b,
    input wire [7:0]       delay_trim_chan_c,
    input wire [7:0]       delay_trim_chan_d
);
    wire [5:0] idx = wb_adr_i[7:2];                               // Register index
    wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o; // Request taken now
    wire       hit = (idx >= 6'h26) && (idx <= 6'h2F);            // Mapped index
    reg  [1:0] mode_reg;                                          // Copy of bits 14 and 0

    // Mirror strobe and constant bits on the edge a control write is taken
    always @(posedge clock) begin
        if (reset) begin
            mode_reg <= 2'h0;
        end else if (req && wb_we_i && idx == 6'h2D) begin
            mode_reg <= {wb_sel_i[1] ? wb_dat_i[14] : mode_reg[1],
                         wb_sel_i[0] ? wb_dat_i[0] : mode_reg[0]};
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    // Full-width write taken at a given index
    sequence s_take(logic [5:0] i);
        req && wb_we_i && wb_sel_i[1:0] == 2'h3 && idx == i;
    endsequence

    property p_ack; req && hit |=> wb_ack_o && !wb_err_o; endproperty
    a_ack: assert property (p_ack) else $error("mapped request not acknowledged");
    property p_err; req && !hit |=> wb_err_o && !wb_ack_o && wb_dat_o == 32'h0; endproperty
    a_err: assert property (p_err) else $error("unmapped request not refused");
    property p_pulse; wb_ack_o |-> wb_dat_o[31:16] == 16'h0 ##1 !wb_ack_o; endproperty
    a_pulse: assert property (p_pulse) else $error("ack too long or high data");
    property p_word; s_take(6'h26) |-> ##2 check_word_one == $past(wb_dat_i[15:0], 2); endproperty
    a_word: assert property (p_word) else $error("check word one not updated");
    property p_trim_ab;
        s_take(6'h2E) |-> ##2 {delay_trim_chan_a, delay_trim_chan_b} == $past(wb_dat_i[15:0], 2);
    endproperty
    a_trim_ab: assert property (p_trim_ab) else $error("trims a b wrong");
    property p_trim_cd;
        s_take(6'h2F) |-> ##2 {delay_trim_chan_c, delay_trim_chan_d} == $past(wb_dat_i[15:0], 2);
    endproperty
    a_trim_cd: assert property (p_trim_cd) else $error("trims c d wrong");
    property p_strobe; !$past(reset) |-> divider_strobe ==
        ($past(mode_reg[1]) ? $past(sync_strobe_in) : $past(divider_clk_src)); endproperty
    a_strobe: assert property (p_strobe) else $error("divider strobe source wrong");
    property p_const; !$past(reset) |-> conv_data ==
        ($past(mode_reg[0]) ? $past(const_word) : $past(proc_data)); endproperty
    a_const: assert property (p_const) else $error("converter data source wrong");
    property p_tx; !$past(reset) |-> conv_tx_enable ==
        ($past(mode_reg[0]) | $past(transmit_gate_pin & transmit_gate_bit)); endproperty
    a_tx: assert property (p_tx) else $error("transmit enable wrong");
endmodule

/* src/dtr_consts.vh */
`ifndef DTR_CONSTS_VH
`define DTR_CONSTS_VH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define DTR_IDX_WORD_ONE    6'h26
`define DTR_IDX_WORD_TWO    6'h27
`define DTR_IDX_WORD_THREE  6'h28
`define DTR_IDX_WORD_FOUR   6'h29
`define DTR_IDX_WORD_FIVE   6'h2A
`define DTR_IDX_WORD_SIX    6'h2B
`define DTR_IDX_WORD_SEVEN  6'h2C
`define DTR_IDX_CONTROL     6'h2D
`define DTR_IDX_DELAY_AB    6'h2E
`define DTR_IDX_DELAY_CD    6'h2F

// ==========================================================================
// Reset values
// ==========================================================================
`define DTR_RST_WORD_ONE    16'hB6B6
`define DTR_RST_WORD_TWO    16'hEAEA
`define DTR_RST_WORD_THREE  16'h4545
`define DTR_RST_WORD_FOUR   16'h1A1A
`define DTR_RST_WORD_FIVE   16'h1616
`define DTR_RST_WORD_SIX    16'hAAAA
`define DTR_RST_WORD_SEVEN  16'hC6C6
`define DTR_RST_CONTROL     16'h0004
`define DTR_RST_DELAY       16'h0000

// ==========================================================================
// Control word fields
// ==========================================================================
`define DTR_BIT_STROBE_SEL  14
`define DTR_BIT_RAMP_ENA    13
`define DTR_BIT_CONST_ENA   0
`define DTR_CTRL_WMASK      16'h6001

// ==========================================================================
// Delay word fields
// ==========================================================================
`define DTR_HI_MSB          15
`define DTR_HI_LSB          8
`define DTR_LO_MSB          7
`define DTR_LO_LSB          0

`endif

/* src/dtr_regs.v */
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "dtr_consts.vh"

// Function
// RQ1 - Seven writable 16-bit check words, 0x26-0x2C
// RQ2 - Words one, two reset B6B6, EAEA
// RQ3 - Words three, four reset 4545, 1A1A
// RQ4 - Words five, six reset 1616, AAAA
// RQ5 - Word seven resets to C6C6
// RQ6 - Bit 14 routes sync strobe to dividers
// RQ7 - Bit 13 injects ramp at FIFO input
// RQ8 - Bit 0 forces constant word outputs
// RQ9 - Constant mode ignores transmit enable bit, pin
// RQ10 - Control word resets to 0x0004
// RQ11 - 0x2E holds delay trims A and B
// RQ12 - 0x2F holds delay trims C and D
// RQ13 - Full-scale delay trim is 30-100 ps
// RQ14 - Delay registers reset to zero
// RQ15 - Source aligns word zero with frame edge (not done here; word zero lies outside this slice)
// RQ16 - Constant word latched only with sample clock
// RQ17 - Reserved control bits ignore writes
module dtr_regs #(
    parameter WIDTH = 16                       // Register data width
) (
    input  wire             clock,             // System clock, 25 MHz
    input  wire             reset,             // Synchronous reset, active high
    input  wire             wb_cyc_i,          // Wishbone cycle
    input  wire             wb_stb_i,          // Wishbone strobe
    input  wire             wb_we_i,           // Wishbone write enable
    input  wire [7:0]       wb_adr_i,          // Wishbone byte address
    input  wire [3:0]       wb_sel_i,          // Wishbone byte lanes
    input  wire [31:0]      wb_dat_i,          // Wishbone write data
    output reg  [31:0]      wb_dat_o,          // Wishbone read data
    output reg              wb_ack_o,          // Wishbone acknowledge
    output reg              wb_err_o,          // Wishbone error on unmapped index
    input  wire             sync_strobe_in,    // External synchronisation strobe
    input  wire             transmit_gate_pin, // Transmit enable pin
    input  wire             transmit_gate_bit, // Transmit enable register bit
    input  wire [WIDTH-1:0] fifo_data_in,      // Incoming samples to FIFO
    input  wire [WIDTH-1:0] ramp_value,        // Generated ramp sample
    input  wire [WIDTH-1:0] proc_data,         // Processed converter data
    input  wire [WIDTH-1:0] const_word,        // Software constant output word
    input  wire             divider_clk_src,   // Normal divider clock source
    output reg              divider_strobe,    // Strobe to the internal dividers
    output reg  [WIDTH-1:0] fifo_data_out,     // Data at the FIFO input
    output reg  [WIDTH-1:0] conv_data,         // Word driven to all converters
    output reg              conv_tx_enable,    // Effective transmit enable
    output reg  [WIDTH-1:0] check_word_one,    // Check words to the pattern checker
    output reg  [WIDTH-1:0] check_word_two,
    output reg  [WIDTH-1:0] check_word_three,
    output reg  [WIDTH-1:0] check_word_four,
    output reg  [WIDTH-1:0] check_word_five,
    output reg  [WIDTH-1:0] check_word_six,
    output reg  [WIDTH-1:0] check_word_seven,
    output reg  [7:0]       delay_trim_chan_a, // Group delay trims
    output reg  [7:0]       delay_trim_chan_b,
    output reg  [7:0]       delay_trim_chan_c,
    output reg  [7:0]       delay_trim_chan_d
);

    // ======================================================================
    // Storage
    // ======================================================================
    reg  [WIDTH-1:0] word_reg [1:7];           // Check words one to seven
    reg  [WIDTH-1:0] control_reg;              // Test and override control
    reg  [WIDTH-1:0] delay_ab_reg;             // Trims A (high) and B (low)
    reg  [WIDTH-1:0] delay_cd_reg;             // Trims C (high) and D (low)
    reg  [WIDTH-1:0] read_next;                // Read mux result
    reg              hit_next;                 // Index is mapped
    wire [5:0]       index;                    // Word index from byte address
    wire             request;                  // New bus request this cycle
    wire [WIDTH-1:0] lane_mask;                // Byte enables as bit mask

    assign index     = wb_adr_i[7:2];
    assign request   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
    assign lane_mask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

    // Merge write data into a register under the byte lanes
    function [15:0] dtr_merge;
        input [15:0] old_val;
        input [15:0] new_val;
        input [15:0] mask;
        begin
            dtr_merge = (old_val & ~mask) | (new_val & mask);
        end
    endfunction

    // Check-word reset value by index
    function [15:0] dtr_word_rst;
        input [2:0] n;
        begin
            case (n)
                3'h1:    dtr_word_rst = `DTR_RST_WORD_ONE;   // RQ2
                3'h2:    dtr_word_rst = `DTR_RST_WORD_TWO;   // RQ2
                3'h3:    dtr_word_rst = `DTR_RST_WORD_THREE; // RQ3
                3'h4:    dtr_word_rst = `DTR_RST_WORD_FOUR;  // RQ3
                3'h5:    dtr_word_rst = `DTR_RST_WORD_FIVE;  // RQ4
                3'h6:    dtr_word_rst = `DTR_RST_WORD_SIX;   // RQ4
                default: dtr_word_rst = `DTR_RST_WORD_SEVEN; // RQ5
            endcase
        end
    endfunction

    // ======================================================================
    // Address decode and read mux
    // ======================================================================
    always @* begin
        read_next = 16'h0000;
        hit_next  = 1'b1;
        if (index >= `DTR_IDX_WORD_ONE && index <= `DTR_IDX_WORD_SEVEN) begin
            // Check words sit at consecutive indices
            read_next = word_reg[index - `DTR_IDX_WORD_ONE + 6'h01]; // RQ1
        end else if (index == `DTR_IDX_CONTROL) begin
            read_next = control_reg;
        end else if (index == `DTR_IDX_DELAY_AB) begin
            read_next = delay_ab_reg;
        end else if (index == `DTR_IDX_DELAY_CD) begin
            read_next = delay_cd_reg;
        end else begin
            hit_next = 1'b0;
        end
    end

    // ======================================================================
    // Bus slave: one wait-free answer, ack or err in the next cycle
    // ======================================================================
    integer i;
    always @(posedge clock) begin
        if (reset) begin
            wb_ack_o     <= 1'b0;
            wb_err_o     <= 1'b0;
            wb_dat_o     <= 32'h0000_0000;
            for (i = 1; i <= 7; i = i + 1) begin
                word_reg[i] <= dtr_word_rst(i[2:0]);
            end
            control_reg  <= `DTR_RST_CONTROL;  // RQ10
            delay_ab_reg <= `DTR_RST_DELAY;    // RQ14
            delay_cd_reg <= `DTR_RST_DELAY;    // RQ14
        end else begin
            wb_ack_o <= request & hit_next;
            wb_err_o <= request & ~hit_next;
            // Unread data lanes stay zero
            wb_dat_o <= (request & hit_next & ~wb_we_i) ? {16'h0000, read_next}
                                                         : 32'h0000_0000;
            if (request & wb_we_i & hit_next) begin
                if (index >= `DTR_IDX_WORD_ONE && index <= `DTR_IDX_WORD_SEVEN) begin
                    word_reg[index - `DTR_IDX_WORD_ONE + 6'h01] <=
                        dtr_merge(word_reg[index - `DTR_IDX_WORD_ONE + 6'h01],
                                  wb_dat_i[15:0], lane_mask); // RQ1
                end else if (index == `DTR_IDX_CONTROL) begin
                    // Only the three live bits take writes
                    control_reg <= dtr_merge(control_reg, wb_dat_i[15:0],
                                             lane_mask & `DTR_CTRL_WMASK); // RQ17
                end else if (index == `DTR_IDX_DELAY_AB) begin
                    delay_ab_reg <= dtr_merge(delay_ab_reg, wb_dat_i[15:0], lane_mask); // RQ11
                end else begin
                    delay_cd_reg <= dtr_merge(delay_cd_reg, wb_dat_i[15:0], lane_mask); // RQ12
                end
            end
        end
    end

    // ======================================================================
    // Override datapath, registered outputs
    // ======================================================================
    always @(posedge clock) begin
        if (reset) begin
            divider_strobe <= 1'b0;
            fifo_data_out  <= 16'h0000;
            conv_data      <= 16'h0000;
            conv_tx_enable <= 1'b0;
        end else begin
            // Strobe routed straight to the dividers when selected
            divider_strobe <= control_reg[`DTR_BIT_STROBE_SEL] ? sync_strobe_in
                                                               : divider_clk_src; // RQ6
            // Ramp replaces incoming samples at the FIFO input
            fifo_data_out  <= control_reg[`DTR_BIT_RAMP_ENA] ? ramp_value
                                                             : fifo_data_in; // RQ7
            if (control_reg[`DTR_BIT_CONST_ENA]) begin
                // Constant word on all outputs, transmit gates ignored
                conv_data      <= const_word;  // RQ8 RQ16
                conv_tx_enable <= 1'b1;        // RQ9
            end else begin
                conv_data      <= proc_data;
                conv_tx_enable <= transmit_gate_pin & transmit_gate_bit;
            end
        end
    end

    // ======================================================================
    // Configuration outputs
    // ======================================================================
    always @(posedge clock) begin
        if (reset) begin
            check_word_one    <= `DTR_RST_WORD_ONE;
            check_word_two    <= `DTR_RST_WORD_TWO;
            check_word_three  <= `DTR_RST_WORD_THREE;
            check_word_four   <= `DTR_RST_WORD_FOUR;
            check_word_five   <= `DTR_RST_WORD_FIVE;
            check_word_six    <= `DTR_RST_WORD_SIX;
            check_word_seven  <= `DTR_RST_WORD_SEVEN;
            delay_trim_chan_a <= 8'h00;
            delay_trim_chan_b <= 8'h00;
            delay_trim_chan_c <= 8'h00;
            delay_trim_chan_d <= 8'h00;
        end else begin
            check_word_one    <= word_reg[1];
            check_word_two    <= word_reg[2];
            check_word_three  <= word_reg[3];
            check_word_four   <= word_reg[4];
            check_word_five   <= word_reg[5];
            check_word_six    <= word_reg[6];
            check_word_seven  <= word_reg[7];
            // Full-scale trim gives the analog maximum delay, 30 to 100 ps
            delay_trim_chan_a <= delay_ab_reg[`DTR_HI_MSB:`DTR_HI_LSB]; // RQ11 RQ13
            delay_trim_chan_b <= delay_ab_reg[`DTR_LO_MSB:`DTR_LO_LSB]; // RQ11
            delay_trim_chan_c <= delay_cd_reg[`DTR_HI_MSB:`DTR_HI_LSB]; // RQ12
            delay_trim_chan_d <= delay_cd_reg[`DTR_LO_MSB:`DTR_LO_LSB]; // RQ12
        end
    end

endmodule
